// ==== hw/pcw_top.sv ====
// counter array with narrow/wide pwm modules and module-5 watchdog, apb register slave
//
// Notes on behaviour
// - reload_select steers compare byte accesses to auto-reload or compare register.
// - n-bit pwm: pin high on low-n-bit match, low on overflow out of bit n.
// - each n-bit overflow sets pwm_overflow_flag and copies reload into narrow compare; eight bits copies high byte to low.
// - narrow pwm when comparator and pwm enabled, wide pwm clear, at any cycle length.
// - narrow pwm with match_flag_enable sets compare_flag on each match.
// - n-bit overflow recurs every 256, 512, 1024 or 2048 counter clocks.
// - low byte write clears comparator_enable, high byte write sets it.
// - comparator disabled holds a pwm output at zero duty.
// - wide pwm when comparator, pwm and wide pwm enables all set.
// - wide pwm: high on 16-bit match, low on 16-bit overflow, flags mark both.
// - watchdog on: module 5 high byte vs counter high, low byte is offset.
// - watchdog enabled after reset, clock /12, bytes zero, 256-clock timeout.
// - watchdog on: counter forced, counter writes, clock, idle, module 5 frozen.
// - watchdog on: counter_run writes harmless, reads the software value only.
// - any watchdog_update_byte write loads counter high plus offset.
// - watchdog reset when low byte overflows while update byte equals high byte.
// - timeout is 256 times offset plus 256 minus low byte at update.
// - writing 1 to module5_compare_flag under watchdog forces immediate reset.
// - enable or lock turns watchdog on; lock holds it until system reset.
// - idle_suspend pauses the count while the processor idles.
// - cycle_length_select 00b selects eight bits, others 9, 10, 11.
//
// Decided for this implementation: the address map and register access over APB.
`include "pcw_defines.svh"

module pcw_top
	import pcw_pkg::*;
#(
	parameter int NUM_MOD = 6,              // capture/compare modules
	parameter int WDT_MOD = 5,              // module that becomes the watchdog
	parameter int ADDR_W  = 8               // apb address width
) (
	input  wire logic               sys_clk,           // system clock, 200 MHz
	input  wire logic               sys_rst,           // synchronous reset, active high
	input  wire logic               psel,              // apb select
	input  wire logic               penable,           // apb access phase
	input  wire logic               pwrite,            // apb write
	input  wire logic [ADDR_W-1:0]  paddr,             // apb byte address
	input  wire logic [31:0]        pwdata,            // apb write data
	output logic      [31:0]        prdata,            // apb read data
	output logic                    pready,            // apb ready
	output logic                    pslverr,           // apb error, unmapped address
	input  wire logic               cpu_idle,          // processor idle mode level
	input  wire logic               ext_tick,          // external counter clock pulse
	output logic      [NUM_MOD-1:0] module_output_pin, // one output per module
	output logic                    wdt_reset          // one-cycle watchdog reset request
);

	// counter state and configuration
	pcw_word_t             cnt;
	logic [3:0]            div_cnt;
	logic                  src_tick;
	logic                  tick;
	logic                  counter_overflow_flag;
	logic                  counter_run;
	logic [NUM_MOD-1:0]    compare_flag;
	logic                  idle_suspend;
	logic                  watchdog_enable;
	logic                  watchdog_lock;
	logic [2:0]            clock_source_select;
	logic                  reload_select;
	logic                  pwm_overflow_flag;
	logic [1:0]            cycle_length_select;
	pcw_byte_t             mode_reg [NUM_MOD];
	pcw_word_t             compare_value [NUM_MOD];
	pcw_word_t             reload_value [NUM_MOD];

	// derived terms
	logic                  wdt_on;
	logic                  run_eff;
	pcw_word_t             cnt_next;
	pcw_word_t             len_mask;
	logic                  narrow_ovf;
	logic                  wide_ovf;
	logic                  low_ovf;
	logic                  wdt_fire;
	logic                  wdt_force;
	pcw_mode_t             mode_eff [NUM_MOD];
	logic [NUM_MOD-1:0]    match_n;
	logic [NUM_MOD-1:0]    match_w;
	logic [NUM_MOD-1:0]    flag_set;

	// bus decode
	logic                  acc;
	logic                  wr;
	logic [ADDR_W-1:0]     a;
	pcw_byte_t             wb;
	logic                  hit_ctrl;
	logic                  hit_amode;
	logic                  hit_pcfg;
	logic                  hit_cntl;
	logic                  hit_cnth;
	logic [NUM_MOD-1:0]    hit_mode;
	logic [NUM_MOD-1:0]    hit_lo;
	logic [NUM_MOD-1:0]    hit_hi;
	logic                  hit_any;
	pcw_byte_t             rd_byte;

	// mask of the pwm cycle length
	// length encoding
	function automatic pcw_word_t cls_mask(input logic [1:0] cls);
		unique case (cls)
			2'b00:   cls_mask = 16'h00FF;
			2'b01:   cls_mask = 16'h01FF;
			2'b10:   cls_mask = 16'h03FF;
			2'b11:   cls_mask = 16'h07FF;
		endcase
	endfunction

	// decode one module mode byte into its operating mode
	function automatic pcw_mode_t decode_mode(input pcw_byte_t m);
		if (m[`PCW_MD_PWM] && m[`PCW_MD_WIDE])
			decode_mode = PCW_WIDE;
		else if (m[`PCW_MD_PWM])
			decode_mode = PCW_NARROW;
		else if (m[`PCW_MD_CMPEN] && m[`PCW_MD_MATCH])
			decode_mode = PCW_TIMER;
		else
			decode_mode = PCW_IDLE;
	endfunction

	// bus strobes; a write lands only at the edge where pready is seen high
	assign acc = psel & penable;
	assign wr  = acc & pwrite & pready;
	assign a   = paddr;
	assign wb  = pwdata[7:0];

	// enable or lock keeps the watchdog on
	assign wdt_on = watchdog_enable | watchdog_lock;
	assign run_eff = counter_run | wdt_on;

	// register address decode
	always_comb begin
		hit_ctrl  = (a == ADDR_W'(`PCW_OFS_CTRL));
		hit_amode = (a == ADDR_W'(`PCW_OFS_AMODE));
		hit_pcfg  = (a == ADDR_W'(`PCW_OFS_PWMCFG));
		hit_cntl  = (a == ADDR_W'(`PCW_OFS_CNTL));
		hit_cnth  = (a == ADDR_W'(`PCW_OFS_CNTH));
		for (int i = 0; i < NUM_MOD; i++) begin
			hit_mode[i] = (a == ADDR_W'(`PCW_OFS_MODE_BASE + 4 * i));
			hit_lo[i]   = (a == ADDR_W'(`PCW_OFS_CMP_BASE + 8 * i));
			hit_hi[i]   = (a == ADDR_W'(`PCW_OFS_CMP_BASE + 8 * i + 4));
		end
		hit_any = hit_ctrl | hit_amode | hit_pcfg | hit_cntl | hit_cnth
			| (|hit_mode) | (|hit_lo) | (|hit_hi);
	end

	// read mux; reserved bits read zero, but module mode bytes read back all eight written bits
	always_comb begin
		rd_byte = 8'h00;
		if (hit_ctrl)
			// run bit shows only what software wrote
			rd_byte = {counter_overflow_flag, counter_run, 6'(compare_flag)};
		if (hit_amode)
			rd_byte = {idle_suspend, watchdog_enable, watchdog_lock, 1'b0,
				clock_source_select, 1'b0};
		if (hit_pcfg)
			rd_byte = {reload_select, 1'b0, pwm_overflow_flag, 3'b000, cycle_length_select};
		if (hit_cntl)
			rd_byte = cnt[7:0];
		if (hit_cnth)
			rd_byte = cnt[15:8];
		for (int i = 0; i < NUM_MOD; i++) begin
			if (hit_mode[i])
				rd_byte = mode_reg[i];
			// reload_select picks the register behind the byte
			if (hit_lo[i])
				rd_byte = reload_select ? reload_value[i][7:0] : compare_value[i][7:0];
			if (hit_hi[i])
				rd_byte = reload_select ? reload_value[i][15:8] : compare_value[i][15:8];
		end
	end

	// apb answer: one wait state, data and error registered with ready
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= acc & ~pready;
			prdata  <= (acc & ~pready & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			pslverr <= acc & ~pready & ~hit_any;
		end
	end

	// counter clock prescaler; /12 is the reset choice
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			div_cnt <= 4'h0;
		end else begin
			if ((clock_source_select == `PCW_CPS_DIV4 && div_cnt >= `PCW_DIV4)
				|| div_cnt >= `PCW_DIV12)
				div_cnt <= 4'h0;
			else
				div_cnt <= div_cnt + 4'h1;
		end
	end

	// source select; unused codes fall back to /12
	always_comb begin
		unique case (clock_source_select)
			`PCW_CPS_DIV4: src_tick = (div_cnt == `PCW_DIV4);
			`PCW_CPS_SYS:  src_tick = 1'b1;
			`PCW_CPS_EXT:  src_tick = ext_tick;
			default:       src_tick = (div_cnt == `PCW_DIV12);
		endcase
	end

	// idle pauses the count when idle_suspend is set
	assign tick = src_tick & run_eff & ~(idle_suspend & cpu_idle);

	assign cnt_next   = cnt + 16'h0001;
	assign len_mask   = cls_mask(cycle_length_select);
	// wrap of the low n bits sets the period
	assign narrow_ovf = tick & ((cnt_next & len_mask) == 16'h0000);
	assign wide_ovf   = tick & (cnt == 16'hFFFF);
	assign low_ovf    = tick & (cnt[7:0] == 8'hFF);

	// per module mode and comparator matches against the coming count
	always_comb begin
		for (int i = 0; i < NUM_MOD; i++) begin
			mode_eff[i] = decode_mode(mode_reg[i]);
			// module 5 forced to software timer
			if (i == WDT_MOD && wdt_on)
				mode_eff[i] = PCW_TIMER;
			match_n[i] = tick & ((cnt_next & len_mask) == (compare_value[i] & len_mask));
			match_w[i] = tick & (cnt_next == compare_value[i]);
			// narrow match flag; wide match flag
			flag_set[i] = mode_reg[i][`PCW_MD_MATCH] & mode_reg[i][`PCW_MD_CMPEN]
				& ((mode_eff[i] == PCW_NARROW) ? match_n[i] : match_w[i])
				& (mode_eff[i] != PCW_IDLE);
		end
	end

	// low byte overflows while update byte equals counter high
	assign wdt_fire  = wdt_on & low_ovf & (compare_value[WDT_MOD][15:8] == cnt[15:8]);
	assign wdt_force = wdt_on & wr & hit_ctrl & wb[WDT_MOD];

	// watchdog reset pulse
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			wdt_reset <= 1'b0;
		else
			wdt_reset <= wdt_fire | wdt_force;
	end

	// shared counter; software writes only while the watchdog is off
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt <= 16'h0000;
		end else begin
			if (wr && hit_cntl && !wdt_on)
				cnt[7:0] <= wb;
			else if (wr && hit_cnth && !wdt_on)
				cnt[15:8] <= wb;
			else if (tick)
				cnt <= cnt_next;
		end
	end

	// control flags; a hardware set beats a software clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			counter_overflow_flag <= 1'b0;
			counter_run           <= 1'b0;
			compare_flag          <= '0;
		end else begin
			if (wr && hit_ctrl) begin
				// stored, but a running watchdog overrides it
				counter_run           <= wb[`PCW_CTRL_CR];
				counter_overflow_flag <= wb[`PCW_CTRL_CF] | wide_ovf;
				compare_flag          <= wb[NUM_MOD-1:0] | flag_set;
			end else begin
				counter_overflow_flag <= counter_overflow_flag | wide_ovf;
				compare_flag          <= compare_flag | flag_set;
			end
		end
	end

	// mode register: clock source and idle frozen under watchdog
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			// watchdog on and /12 after reset
			idle_suspend        <= 1'(`PCW_AMODE_RST >> `PCW_AM_IDLE);
			watchdog_enable     <= 1'b1;
			watchdog_lock       <= 1'b0;
			clock_source_select <= `PCW_CPS_DIV12;
		end else if (wr && hit_amode) begin
			// lock can only be set; reset alone clears it
			watchdog_enable <= wb[`PCW_AM_WDE];
			watchdog_lock   <= watchdog_lock | wb[`PCW_AM_LOCK];
			if (!wdt_on) begin
				idle_suspend        <= wb[`PCW_AM_IDLE];
				clock_source_select <= wb[`PCW_AM_CPS_H:`PCW_AM_CPS_L];
			end
		end
	end

	// pwm config: overflow flag set wins over a clearing write
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			reload_select       <= 1'b0;
			pwm_overflow_flag   <= 1'b0;
			cycle_length_select <= 2'b00;
		end else if (wr && hit_pcfg) begin
			reload_select       <= wb[`PCW_PC_RELOAD_SELECT];
			pwm_overflow_flag   <= wb[`PCW_PC_PWM_OVERFLOW_FLAG] | narrow_ovf;
			cycle_length_select <= wb[`PCW_PC_CLS_H:`PCW_PC_CLS_L];
		end else begin
			pwm_overflow_flag <= pwm_overflow_flag | narrow_ovf;
		end
	end

	// module mode bytes; compare byte writes also move comparator_enable
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_MOD; i++)
				mode_reg[i] <= `PCW_BYTE_RST;
		end else begin
			for (int i = 0; i < NUM_MOD; i++) begin
				if (!(i == WDT_MOD && wdt_on)) begin
					if (wr && hit_mode[i])
						mode_reg[i] <= wb;
					// low write clears, high write sets the comparator
					else if (wr && hit_lo[i])
						mode_reg[i][`PCW_MD_CMPEN] <= 1'b0;
					else if (wr && hit_hi[i])
						mode_reg[i][`PCW_MD_CMPEN] <= 1'b1;
				end
			end
		end
	end

	// auto-reload registers, right-justified
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_MOD; i++)
				reload_value[i] <= 16'h0000;
		end else begin
			for (int i = 0; i < NUM_MOD; i++) begin
				// reload side of the dual map
				if (wr && reload_select && hit_lo[i])
					reload_value[i][7:0] <= wb;
				if (wr && reload_select && hit_hi[i])
					reload_value[i][15:8] <= wb;
			end
		end
	end

	// compare registers: software writes, watchdog update and overflow reload
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_MOD; i++)
				compare_value[i] <= 16'h0000;
		end else begin
			for (int i = 0; i < NUM_MOD; i++) begin
				if (i == WDT_MOD && wdt_on && wr && hit_hi[i]) begin
					// update byte ignores the data; offset adds whole pages
					compare_value[i][15:8] <= cnt[15:8] + compare_value[i][7:0];
				end else if (wr && !reload_select && hit_lo[i]) begin
					compare_value[i][7:0] <= wb;
				end else if (wr && !reload_select && hit_hi[i]) begin
					compare_value[i][15:8] <= wb;
				end else if (narrow_ovf && mode_eff[i] == PCW_NARROW) begin
					// reload on each overflow; eight bits takes the high byte
					if (cycle_length_select == 2'b00)
						compare_value[i][7:0] <= compare_value[i][15:8];
					else
						compare_value[i] <= reload_value[i];
				end
			end
		end
	end

	// output pins; a match in the wrap tick wins so a zero compare gives full duty
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			module_output_pin <= '0;
		end else begin
			for (int i = 0; i < NUM_MOD; i++) begin
				unique case (mode_eff[i])
					PCW_NARROW: begin
						if (!mode_reg[i][`PCW_MD_CMPEN])
							module_output_pin[i] <= 1'b0;
						// set on match, clear on n-bit overflow; mode
						else if (match_n[i])
							module_output_pin[i] <= 1'b1;
						else if (narrow_ovf)
							module_output_pin[i] <= 1'b0;
					end
					PCW_WIDE: begin
						// wide mode ignores the length select
						if (!mode_reg[i][`PCW_MD_CMPEN])
							module_output_pin[i] <= 1'b0;
						// set on 16-bit match, clear on 16-bit overflow
						else if (match_w[i])
							module_output_pin[i] <= 1'b1;
						else if (tick && cnt_next == 16'h0000)
							module_output_pin[i] <= 1'b0;
					end
					// timer and idle modes leave the pin where it is
					default: module_output_pin[i] <= module_output_pin[i];
				endcase
			end
		end
	end

endmodule // pcw_top

// ==== hw/pcw_defines.svh ====
// register offsets, field positions, reset values and timing counts of the pwm/watchdog block
`ifndef PCW_DEFINES_SVH
`define PCW_DEFINES_SVH

// byte offsets on the register bus
`define PCW_OFS_CTRL      8'h00
`define PCW_OFS_AMODE     8'h04
`define PCW_OFS_PWMCFG    8'h08
`define PCW_OFS_CNTL      8'h0C
`define PCW_OFS_CNTH      8'h10
`define PCW_OFS_MODE_BASE 8'h40
`define PCW_OFS_CMP_BASE  8'h60

// array_control_reg fields
`define PCW_CTRL_CF  7
`define PCW_CTRL_CR  6
// array_mode_reg fields
`define PCW_AM_IDLE  7
`define PCW_AM_WDE   6
`define PCW_AM_LOCK  5
`define PCW_AM_CPS_H 3
`define PCW_AM_CPS_L 1
// pwm_config_reg fields
`define PCW_PC_RELOAD_SELECT 7
`define PCW_PC_PWM_OVERFLOW_FLAG  5
`define PCW_PC_CLS_H 1
`define PCW_PC_CLS_L 0
// module_mode_reg fields
`define PCW_MD_WIDE  7
`define PCW_MD_CMPEN 6
`define PCW_MD_MATCH 3
`define PCW_MD_PWM   1

// reset values
`define PCW_AMODE_RST 8'h40
`define PCW_BYTE_RST  8'h00

// clock source encodings and prescale
`define PCW_CPS_DIV12 3'h0
`define PCW_CPS_DIV4  3'h1
`define PCW_CPS_SYS   3'h2
`define PCW_CPS_EXT   3'h3
`define PCW_DIV12     4'hB
`define PCW_DIV4      4'h3

`endif

// ==== hw/pcw_pkg.sv ====
// types shared by the pwm/watchdog block
package pcw_pkg;

	// effective operating mode of one module
	typedef enum logic [1:0] {
		PCW_IDLE,
		PCW_TIMER,
		PCW_NARROW,
		PCW_WIDE
	} pcw_mode_t;

	typedef logic [7:0]  pcw_byte_t;
	typedef logic [15:0] pcw_word_t;

endpackage

// ==== tb/pcw_top_sva.sv ====
// assertion checker for the pwm/watchdog block, bound to its top module
module pcw_top_sva (
	input wire logic        sys_clk,   // system clock
	input wire logic        sys_rst,   // synchronous reset
	input wire logic        psel,      // apb select
	input wire logic        penable,   // apb access phase
	input wire logic        pwrite,    // apb write
	input wire logic [7:0]  paddr,     // apb address
	input wire logic [31:0] pwdata,    // apb write data
	input wire logic [31:0] prdata,    // apb read data
	input wire logic        pready,    // apb ready
	input wire logic        pslverr,   // apb error
	input wire logic        wdt_reset  // watchdog reset pulse
);
	logic        wr_done;
	logic        wd_on;
	logic        wd_lock;
	logic        quiet;
	logic        fired;
	logic [11:0] since_rst;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	assign wr_done = psel && penable && pready && pwrite;

	// watchdog state follows completed mode writes; lock sticks until reset
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wd_on   <= 1'b1;
			wd_lock <= 1'b0;
		end else if (wr_done && paddr == 8'h04) begin
			wd_on   <= pwdata[6] | pwdata[5] | wd_lock;
			wd_lock <= wd_lock | pwdata[5];
		end
	end

	// age since reset while software has written nothing
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			since_rst <= 12'h000;
			quiet     <= 1'b1;
			fired     <= 1'b0;
		end else begin
			if (since_rst != 12'hFFF) begin
				since_rst <= since_rst + 12'h001;
			end
			quiet <= quiet & ~wr_done;
			fired <= fired | wdt_reset;
		end
	end

	AST_READY_PULSE: assert property (
		pready |=> !pready) else $error("ready longer than one cycle");
	AST_READY_WAIT: assert property (
		psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("ready not after one wait state");
	AST_ERR_WITH_READY: assert property (
		(pslverr || prdata != 32'h0) |-> pready) else $error("response outside ready");
	AST_UNMAPPED: assert property (
		psel && penable && pready && paddr == 8'h20 |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	AST_WDT_ONE: assert property (
		wdt_reset |=> !wdt_reset) else $error("watchdog reset wider than one cycle");
	AST_WDT_ENABLED: assert property (
		wdt_reset |-> wd_on || $past(wd_on)) else $error("watchdog reset while disabled");
	AST_FORCE: assert property (
		wr_done && paddr == 8'h00 && pwdata[5] && wd_on |-> ##[1:2] wdt_reset)
		else $error("forced watchdog reset missing");
	AST_WDT_NOT_EARLY: assert property (
		quiet && since_rst < 12'hBEA |-> !wdt_reset) else $error("boot timeout too early");
	AST_WDT_ON_TIME: assert property (
		quiet && since_rst == 12'hC1C |-> fired) else $error("boot timeout missing");
endmodule // pcw_top_sva

bind pcw_top pcw_top_sva i_sva (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .wdt_reset(wdt_reset)
);

// ==== tb/pcw_top_tb.sv ====
// self-checking bench for the pwm/watchdog block
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fail_count++; \
	$display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end

module pcw_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic        cpu_idle = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        wdt_reset;
	logic [5:0]  pins;
	logic [31:0] rd;
	logic        er;
	int          fail_count = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          n_wdt = 0;
	int          t_wdt = 0;
	int          t0, k, n, hi, per, nb, c;

	always #2.5 sys_clk = ~sys_clk;

	pcw_top i_dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle), .ext_tick(1'b0),
		.module_output_pin(pins), .wdt_reset(wdt_reset)
	);

	// cycle ceiling well above the ~20k cycles the tests need; pulses counted here
	always @(posedge sys_clk) begin
		cyc++;
		if (wdt_reset === 1'b1) begin
			n_wdt++;
			t_wdt = cyc;
		end
		if (cyc == 40000) begin
			fail_count++;
			end_sim();
		end
	end

	task end_sim;
		if (fail_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// one apb transfer; the idle cycle after it keeps psel from toggling twice
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	// high time and length of one pwm period, optionally aligned to a falling edge
	task automatic meas(input int m, input bit al, output int h, output int p);
		h = 0;
		p = 0;
		if (al) begin
			while (pins[m] !== 1'b1) @(posedge sys_clk);
			while (pins[m] !== 1'b0) @(posedge sys_clk);
		end
		while (pins[m] !== 1'b1) begin @(posedge sys_clk); p++; end
		while (pins[m] === 1'b1) begin @(posedge sys_clk); p++; h++; end
	endtask

	initial begin
		void'($urandom(19148));
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t0 = cyc;
		apb(0, 8'h04, 0); `CHK("mode reset", 8'h40, rd[7:0])
		apb(0, 8'h00, 0); `CHK("run bit", 1'b0, rd[6])
		apb(0, 8'h20, 0); `CHK("unmapped", 1'b1, er)
		wait (n_wdt > 0);
		`CHK("boot timeout", 1'b1, t_wdt - t0 >= 3060 && t_wdt - t0 <= 3084)
		// frozen fields while the watchdog runs
		apb(1, 8'h04, 32'h44);
		apb(0, 8'h04, 0); `CHK("source frozen", 8'h40, rd[7:0])
		apb(1, 8'h10, 32'h55);
		apb(0, 8'h10, 0); `CHK("count write", 1'b1, rd[7:0] != 8'h55)
		// timeout from a known low byte at update, two offsets
		for (int off = 1; off <= 2; off++) begin
			// disable first, then clock source, offset, enable, update
			apb(1, 8'h04, 32'h00);
			apb(1, 8'h04, 32'h04);
			apb(1, 8'h00, 32'h00);
			apb(1, 8'h0C, 32'h80);
			apb(1, 8'h10, 32'h00);
			apb(1, 8'h88, off);
			apb(1, 8'h04, 32'h44);
			k = n_wdt;
			apb(1, 8'h8C, 32'hA5);
			t0 = cyc;
			apb(0, 8'h8C, 0); `CHK("update byte", off[7:0], rd[7:0])
			apb(0, 8'h00, 0); `CHK("run forced", 1'b0, rd[6])
			wait (n_wdt > k);
			`CHK("timeout", 1'b1, t_wdt-t0 >= 256*off+120 && t_wdt-t0 <= 256*off+132)
		end
		// forced reset, then again under lock with the enable cleared
		for (int lk = 0; lk < 2; lk++) begin
			if (lk == 1) begin
				apb(1, 8'h04, 32'h20);
				apb(1, 8'h04, 32'h00);
			end
			k = n_wdt;
			apb(1, 8'h00, 32'h20);
			repeat (3) @(posedge sys_clk);
			`CHK("forced reset", k + 1, n_wdt)
		end
		sys_rst <= 1'b1;
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		// clock source only moves once the watchdog is off
		apb(1, 8'h04, 32'h00);
		apb(1, 8'h04, 32'h84);
		cpu_idle <= 1'b1;
		apb(1, 8'h00, 32'h40);
		apb(0, 8'h0C, 0); `CHK("idle hold", 8'h00, rd[7:0])
		cpu_idle <= 1'b0;
		apb(0, 8'h0C, 0); `CHK("idle release", 1'b1, rd[7:0] != 8'h00)
		// narrow pwm on module 0 through the reload register
		for (int cls = 1; cls <= 3; cls++) begin
			nb = 8 + cls;
			apb(1, 8'h00, 32'h40);
			c = 1 + $urandom % ((1 << nb) - 1);
			apb(1, 8'h08, 32'h80 | cls);
			apb(1, 8'h40, 32'h4A);
			apb(1, 8'h60, c & 8'hFF);
			apb(0, 8'h40, 0); `CHK("enable cleared", 1'b0, rd[6])
			apb(1, 8'h64, c >> 8);
			apb(0, 8'h40, 0); `CHK("enable set", 1'b1, rd[6])
			apb(0, 8'h60, 0); `CHK("reload read", c[7:0], rd[7:0])
			meas(0, 1'b1, hi, per);
			`CHK("period", 1 << nb, per)
			`CHK("high time", (1 << nb) - c, hi)
			apb(0, 8'h08, 0); `CHK("overflow flag", 1'b1, rd[5])
			apb(0, 8'h00, 0); `CHK("match flag", 1'b1, rd[0])
			apb(1, 8'h60, 0);
			n = 0;
			repeat ((1 << nb) + 8) begin @(posedge sys_clk); if (pins[0] !== 1'b0) n++; end
			`CHK("zero duty", 0, n)
		end
		// wide pwm on module 1 from a preset count
		// match flag enabled, compare written low then high while stopped
		apb(1, 8'h00, 32'h00);
		apb(1, 8'h08, 32'h00);
		apb(1, 8'h0C, 32'h00);
		apb(1, 8'h10, 32'hFE);
		apb(1, 8'h44, 32'hCA);
		apb(1, 8'h68, 32'h00);
		apb(1, 8'h6C, 32'hFF);
		apb(1, 8'h00, 32'h40);
		meas(1, 1'b0, hi, per);
		`CHK("wide high", 256, hi)
		`CHK("wide fall", 1'b1, per >= 510 && per <= 516)
		apb(0, 8'h00, 0); `CHK("wide flags", 2'b11, {rd[7], rd[1]})
		end_sim();
	end
endmodule // pcw_top_tb
